/* hw/rlc_map.svh */
// Register map, field positions, codes and tokens of the remote/local range-hold controller.
// Assumes a 32-bit AHB-Lite register bus and the package rlc_pkg for the types.
`ifndef RLC_MAP_SVH
`define RLC_MAP_SVH

// Byte addresses of the registers
`define RLC_OFS_CMD 32'h0000_0000
`define RLC_OFS_STATUS 32'h0000_0004
`define RLC_OFS_RESP 32'h0000_0008
`define RLC_OFS_RANGE 32'h0000_000C

// Command codes written to the command register
`define RLC_CODE_QUERY 8'h01
`define RLC_CODE_REMOTE 8'h02
`define RLC_CODE_LOCAL 8'h03

// Status register bit positions
`define RLC_ST_BUSY 0
`define RLC_ST_REMOTE 1
`define RLC_ST_PANEL_KEYS_DISABLE_CMD 2
`define RLC_ST_HOLD 3
`define RLC_ST_RESP_VALID 4
`define RLC_ST_REFUSED 5

// Answer tokens, ASCII right aligned
`define RLC_TOK_ON 32'h0000_4F4E
`define RLC_TOK_OFF 32'h004F_4646

// Widths, key and bus codes, and reset values
`define RLC_RANGE_W 2
`define RLC_KEY_W 8
`define RLC_KEY_LOCAL 8'h00
`define RLC_HTRANS_NONSEQ 2'h2
`define RLC_WORD_ZERO 32'h0000_0000

`endif

/* hw/rlc_pkg.sv */
// Types shared by the remote/local range-hold controller.
// Assumes rlc_map.svh for all numeric constants.
`default_nettype none
`include "rlc_map.svh"

package rlc_pkg;

    typedef enum logic [1:0] {
        RLC_IDLE,
        RLC_EXEC
    } rlc_state_t;

    typedef struct packed {
        logic [`RLC_KEY_W-1:0] code;
        logic valid;
    } rlc_key_t;

    typedef struct packed {
        logic remote;
        logic panel_keys_disable_cmd;
    } rlc_mode_t;

endpackage

`default_nettype wire

/* hw/rlc_key_gate.sv */
// Front-panel key gate: passes or drops key events by remote and panel_keys_disable_cmd state.
// Assumes key events are one-cycle pulses from logic on clk_sys.
`default_nettype none
`include "rlc_map.svh"

module rlc_key_gate
    import rlc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Mode
    input wire rlc_mode_t mode,
    // Keys
    input wire rlc_key_t key_in,
    output rlc_key_t key_out
);

    function automatic logic is_local_key(input logic [`RLC_KEY_W-1:0] code);
        is_local_key = (code == `RLC_KEY_LOCAL);
    endfunction

    logic pass;

    always_comb begin
        if (!mode.remote) begin
            pass = 1'b1;
        end else if (mode.panel_keys_disable_cmd) begin
            pass = 1'b0;
        end else begin
            pass = is_local_key(key_in.code);
        end
    end

    // Registered so the panel sees clean, glitch-free key events
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            key_out <= '0;
        end else begin
            key_out.valid <= key_in.valid & pass;
            key_out.code <= key_in.code;
        end
    end

endmodule

`default_nettype wire

/* hw/rlc_ctrl.sv */
// Remote/local and range-hold controller: AHB-Lite command and status registers,
// remote/panel_keys_disable_cmd state, held output range and front-panel key gating.
// Assumes a host command handler on AHB-Lite and a panel on the same clk_sys.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
`include "rlc_map.svh"

module rlc_ctrl
    import rlc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Range hold
    input wire logic range_hold_pin,
    input wire logic [`RLC_RANGE_W-1:0] auto_range,
    output logic [`RLC_RANGE_W-1:0] active_range,
    // Remote sources on clk_sys
    input wire logic bus_remote_enable,
    input wire logic panel_keys_disable_set,
    output logic remote_state,
    output logic panel_keys_disable_cmd_state,
    // Front-panel keys
    input wire logic key_valid,
    input wire logic [`RLC_KEY_W-1:0] key_code,
    output logic key_pass_valid,
    output logic [`RLC_KEY_W-1:0] key_pass_code
);

    // Bus address phase, captured for the data phase
    logic wr_pend_q;
    logic [31:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic addr_ok;

    // Command engine
    rlc_state_t state_q;
    logic [7:0] cmd_q;
    logic cmd_wr;
    logic resp_rd;
    logic [31:0] resp_q;
    logic resp_valid_q;
    logic refused_q;
    logic refused_clr;

    // Mode
    logic remote_q;
    logic panel_keys_disable_cmd_q;

    // Range hold pin synchroniser
    logic rh_s1_q;
    logic rh_s2_q;
    logic rh_s3_q;
    logic hold_q;
    logic [`RLC_RANGE_W-1:0] range_q;

    // Keys
    rlc_mode_t mode;
    rlc_key_t key_in;
    rlc_key_t key_out;

    // Zero-wait slave: every transfer finishes in its first data-phase cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign addr_ok = hsel & hready & (htrans == `RLC_HTRANS_NONSEQ);

    function automatic logic [31:0] status_word(
        input logic busy,
        input logic rem,
        input logic lck,
        input logic hld,
        input logic rv,
        input logic rf
    );
        status_word = `RLC_WORD_ZERO;
        status_word[`RLC_ST_BUSY] = busy;
        status_word[`RLC_ST_REMOTE] = rem;
        status_word[`RLC_ST_PANEL_KEYS_DISABLE_CMD] = lck;
        status_word[`RLC_ST_HOLD] = hld;
        status_word[`RLC_ST_RESP_VALID] = rv;
        status_word[`RLC_ST_REFUSED] = rf;
    endfunction

    // Write address phase
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= `RLC_WORD_ZERO;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok & hwrite) begin
                wr_addr_q <= haddr;
            end
        end
    end

    // Read data is loaded at the address phase so it stands through the data phase
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata_q <= `RLC_WORD_ZERO;
        end else if (addr_ok & !hwrite) begin
            case (haddr)
                `RLC_OFS_STATUS: begin
                    hrdata_q <= status_word(state_q != RLC_IDLE, remote_q, panel_keys_disable_cmd_q,
                                            hold_q, resp_valid_q, refused_q);
                end
                `RLC_OFS_RESP: begin
                    hrdata_q <= resp_q;
                end
                `RLC_OFS_RANGE: begin
                    hrdata_q <= {{(32 - `RLC_RANGE_W){1'b0}}, range_q};
                end
                default: begin
                    hrdata_q <= `RLC_WORD_ZERO;
                end
            endcase
        end
    end

    assign cmd_wr = wr_pend_q & (wr_addr_q == `RLC_OFS_CMD);
    assign resp_rd = addr_ok & !hwrite & (haddr == `RLC_OFS_RESP);
    assign refused_clr = wr_pend_q & (wr_addr_q == `RLC_OFS_STATUS) & hwdata[`RLC_ST_REFUSED];

    // Command engine: a write while busy is dropped and flagged
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= RLC_IDLE;
            cmd_q <= '0;
        end else begin
            case (state_q)
                RLC_IDLE: begin
                    if (cmd_wr) begin
                        cmd_q <= hwdata[7:0];
                        state_q <= RLC_EXEC;
                    end
                end
                RLC_EXEC: begin
                    state_q <= RLC_IDLE;
                end
                default: begin
                    state_q <= RLC_IDLE;
                end
            endcase
        end
    end

    // Refused flag: a new refusal wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            refused_q <= 1'b0;
        end else if (cmd_wr & (state_q != RLC_IDLE)) begin
            refused_q <= 1'b1;
        end else if (refused_clr) begin
            refused_q <= 1'b0;
        end
    end

    // Query answer; reading the answer clears its valid flag unless a new one lands
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            resp_q <= `RLC_TOK_OFF;
            resp_valid_q <= 1'b0;
        end else if ((state_q == RLC_EXEC) & (cmd_q == `RLC_CODE_QUERY)) begin
            resp_q <= hold_q ? `RLC_TOK_ON : `RLC_TOK_OFF;
            resp_valid_q <= 1'b1;
        end else if (resp_rd) begin
            resp_valid_q <= 1'b0;
        end
    end

    // Remote and panel_keys_disable_cmd; reset stands for the power cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            remote_q <= 1'b0;
            panel_keys_disable_cmd_q <= 1'b0;
        end else if ((state_q == RLC_EXEC) & (cmd_q == `RLC_CODE_LOCAL)) begin
            remote_q <= 1'b0;
            panel_keys_disable_cmd_q <= 1'b0;
        end else begin
            if (((state_q == RLC_EXEC) & (cmd_q == `RLC_CODE_REMOTE)) | bus_remote_enable) begin
                remote_q <= 1'b1;
            end
            if (panel_keys_disable_set) begin
                panel_keys_disable_cmd_q <= 1'b1;
            end
        end
    end

    // Range-hold pin: three stages, change accepted when the last two agree
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rh_s1_q <= 1'b0;
            rh_s2_q <= 1'b0;
            rh_s3_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            rh_s1_q <= range_hold_pin;
            rh_s2_q <= rh_s1_q;
            rh_s3_q <= rh_s2_q;
            if (rh_s2_q == rh_s3_q) begin
                hold_q <= rh_s3_q;
            end
        end
    end

    // While held, the range in use at the moment of hold is kept
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            range_q <= '0;
        end else if (!hold_q) begin
            range_q <= auto_range;
        end
    end

    assign active_range = range_q;
    assign remote_state = remote_q;
    assign panel_keys_disable_cmd_state = panel_keys_disable_cmd_q;

    // Key gating
    assign mode.remote = remote_q;
    assign mode.panel_keys_disable_cmd = panel_keys_disable_cmd_q;
    assign key_in.valid = key_valid;
    assign key_in.code = key_code;

    rlc_key_gate u_key_gate (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mode(mode),
        .key_in(key_in),
        .key_out(key_out)
    );

    assign key_pass_valid = key_out.valid;
    assign key_pass_code = key_out.code;

endmodule

`default_nettype wire

/* tb/rlc_ctrl_monitor.sv */
// Port checker for the range-hold controller.
// Assumes one clk_sys domain and hready tied to hreadyout.
`default_nettype none
`include "rlc_map.svh"
module rlc_ctrl_monitor (
    // Clock, reset, bus
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Range, mode, keys
    input wire logic range_hold_pin,
    input wire logic [`RLC_RANGE_W-1:0] active_range,
    input wire logic bus_remote_enable,
    input wire logic panel_keys_disable_set,
    input wire logic remote_state,
    input wire logic panel_keys_disable_cmd_state,
    input wire logic key_valid,
    input wire logic [`RLC_KEY_W-1:0] key_code,
    input wire logic key_pass_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_req(a, w);
        hsel && hready && htrans == `RLC_HTRANS_NONSEQ && hwrite == w && haddr == a;
    endsequence
    sequence s_cmd(c);
        s_req(`RLC_OFS_CMD, 1'b1) ##1 hwdata[7:0] == c;
    endsequence
    AST_RESP: assert property (s_req(`RLC_OFS_RESP, 1'b0) |=>
        hrdata == `RLC_TOK_ON || hrdata == `RLC_TOK_OFF) else $error("bad token");
    AST_REM_CMD: assert property (s_cmd(`RLC_CODE_REMOTE) |-> ##[1:3] remote_state)
        else $error("remote cmd");
    AST_LOC_CMD: assert property (s_cmd(`RLC_CODE_LOCAL) |->
        ##[1:3] !remote_state && !panel_keys_disable_cmd_state) else $error("local cmd");
    AST_REM_BUS: assert property (bus_remote_enable |=> remote_state)
        else $error("remote enable");
    AST_LCK_SET: assert property ($rose(panel_keys_disable_set) |=> panel_keys_disable_cmd_state)
        else $error("panel_keys_disable_cmd");
    AST_KEY_LOC: assert property (key_valid && !remote_state |=> key_pass_valid)
        else $error("local key");
    AST_KEY_REM: assert property (key_valid && remote_state && !panel_keys_disable_cmd_state |=>
        key_pass_valid == ($past(key_code) == `RLC_KEY_LOCAL)) else $error("remote key");
    AST_KEY_LCK: assert property (key_valid && panel_keys_disable_cmd_state && remote_state
        |=> !key_pass_valid) else $error("panel_keys_disable_cmd key");
    AST_HOLD: assert property (range_hold_pin [*6] |=> $stable(active_range))
        else $error("range moved");
endmodule
bind rlc_ctrl rlc_ctrl_monitor i_rlc_ctrl_monitor (.clk_sys, .nrst, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .hrdata, .range_hold_pin, .active_range, .bus_remote_enable,
    .panel_keys_disable_set, .remote_state, .panel_keys_disable_cmd_state, .key_valid, .key_code,
    .key_pass_valid);
`default_nettype wire

/* tb/rlc_host.sv */
// Host model: single-word AHB-Lite transfers, commands one at a time.
// Assumes the one slave's hreadyout is hready.
`default_nettype none
`include "rlc_map.svh"
module rlc_host (
    // Clock and answer
    input wire logic clk_sys,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // Released address and data lines show the inverse so a stale copy never matches
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `RLC_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
        hwdata <= ~d;
    endtask
    task automatic cmd(input logic [7:0] c);
        logic [31:0] r;
        xfer(1'b1, `RLC_OFS_CMD, {24'h00_0000, c}, r);
        repeat (2) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* tb/tb_remote_local_range_lock_ctrl.sv */
// Self-checking bench for the range-hold controller.
// Assumes rlc_ctrl, rlc_host and the bound checker are compiled first.
`default_nettype none
`include "rlc_map.svh"
module tb_remote_local_range_lock_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, range_hold_pin;
    logic bus_remote_enable, panel_keys_disable_set, remote_state, panel_keys_disable_cmd_state;
    logic key_valid, key_pass_valid;
    logic [1:0] htrans, auto_range, active_range, held;
    logic [2:0] hsize;
    logic [7:0] key_code, key_pass_code, c;
    logic [31:0] haddr, hwdata, hrdata, r;
    integer seed = 75581;
    int err_count = 0;
    int n_tests = 0;
    wire logic hready = hreadyout;
    rlc_ctrl i_rlc_ctrl (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .range_hold_pin, .auto_range, .active_range,
        .bus_remote_enable, .panel_keys_disable_set, .remote_state, .panel_keys_disable_cmd_state,
        .key_valid, .key_code, .key_pass_valid, .key_pass_code);
    rlc_host i_rlc_host (.clk_sys, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function logic [31:0] f_tok(input logic h);
        return h ? `RLC_TOK_ON : `RLC_TOK_OFF;
    endfunction
    function logic f_key(input logic rem, input logic lck, input logic [7:0] k);
        return !rem || (!lck && k == `RLC_KEY_LOCAL);
    endfunction
    task rd(input logic [31:0] a);
        i_rlc_host.xfer(1'b0, a, `RLC_WORD_ZERO, r);
        chk({30'h0, hresp, hreadyout}, 32'h0000_0001);
    endtask
    task key(input logic [7:0] k, input logic rem, input logic lck);
        key_valid <= 1'b1;
        key_code <= k;
        @(posedge clk_sys);
        key_valid <= 1'b0;
        key_code <= ~k;
        #1 chk({31'h0, key_pass_valid}, {31'h0, f_key(rem, lck, k)});
        if (f_key(rem, lck, k)) chk({24'h0, key_pass_code}, {24'h0, k});
        @(posedge clk_sys);
    endtask
    task rst;
        nrst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
    endtask
    // Span well above the hundred or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        finish_test;
    end
    initial begin
        nrst = 1'b0;
        range_hold_pin = 1'b0;
        auto_range = 2'h0;
        bus_remote_enable = 1'b0;
        panel_keys_disable_set = 1'b0;
        key_valid = 1'b0;
        key_code = 8'h00;
        rst;
        rd(`RLC_OFS_RESP);
        chk(r, `RLC_TOK_OFF);
        rd(32'h0000_0010);
        chk(r, 32'h0000_0000);
        $display("test reset done");
        for (int h = 0; h < 3; h++) begin
            range_hold_pin <= h[0];
            auto_range <= 2'($random(seed));
            repeat (6) @(posedge clk_sys);
            held = auto_range;
            auto_range <= 2'($random(seed));
            repeat (3) @(posedge clk_sys);
            rd(`RLC_OFS_RANGE);
            chk(r, {30'h0, h[0] ? held : auto_range});
            i_rlc_host.cmd(`RLC_CODE_QUERY);
            rd(`RLC_OFS_RESP);
            chk(r, f_tok(h[0]));
        end
        $display("test range done");
        for (int m = 0; m < 3; m++) begin
            if (m == 1) i_rlc_host.cmd(`RLC_CODE_REMOTE);
            if (m == 2) begin
                panel_keys_disable_set <= 1'b1;
                @(posedge clk_sys);
                panel_keys_disable_set <= 1'b0;
                @(posedge clk_sys);
            end
            c = 8'($random(seed));
            if (c == `RLC_KEY_LOCAL) c = 8'h5A;
            key(`RLC_KEY_LOCAL, m > 0, m > 1);
            key(c, m > 0, m > 1);
            rd(`RLC_OFS_STATUS);
            chk(r, {29'h0, m > 1, m > 0, 1'b0});
        end
        i_rlc_host.cmd(`RLC_CODE_LOCAL);
        chk({30'h0, remote_state, panel_keys_disable_cmd_state}, 32'h0000_0000);
        key(c, 1'b0, 1'b0);
        bus_remote_enable <= 1'b1;
        @(posedge clk_sys);
        bus_remote_enable <= 1'b0;
        @(posedge clk_sys);
        chk({31'h0, remote_state}, 32'h0000_0001);
        rst;
        chk({31'h0, remote_state}, 32'h0000_0000);
        $display("test keys done");
        // Back to back commands, one idle bus cycle between the two address phases
        i_rlc_host.xfer(1'b1, `RLC_OFS_CMD, {24'h0, `RLC_CODE_QUERY}, r);
        i_rlc_host.cmd(`RLC_CODE_REMOTE);
        // Clearing the refused flag must leave the rest of the status alone
        i_rlc_host.xfer(1'b1, `RLC_OFS_STATUS, 32'h0000_0020, r);
        rd(`RLC_OFS_STATUS);
        chk(r, 32'h0000_0012);
        $display("test sequence done");
        finish_test;
    end
endmodule
`default_nettype wire
